/* pause_fc_pkg.sv */
// Purpose: shared constants and carriers for the pause flow control block
// Assumes: one 50 MHz clock, classic Wishbone register access
// Notes: frame fields are carried as packed structs
package pause_fc_pkg;
	// wishbone register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SA_LO_OFS = 8'h04;
	localparam logic [7:0] SA_HI_OFS = 8'h08;
	localparam logic [7:0] REFRESH_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	// control register bit positions
	localparam int CTRL_TX_EN_BIT = 0;
	localparam int CTRL_RX_EN_BIT = 1;
	localparam int CTRL_LEN_DIS_BIT = 2;
	localparam int CTRL_PFC_MODE_BIT = 3;
	localparam int CTRL_AUTO_XON_BIT = 4;
	localparam int CTRL_WIDTH = 5;
	// reset values
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;
	localparam logic [47:0] SA_RESET = 48'h0000_0000_0000;
	localparam logic [15:0] REFRESH_RESET = 16'hFF00;
	// frame field constants
	localparam logic [47:0] PAUSE_MCAST_DA = 48'h0180_C200_0001;
	localparam logic [15:0] CTRL_TYPE = 16'h8808;
	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
	localparam logic [15:0] CTRL_FRAME_BYTES = 16'h0040;
	localparam logic [15:0] ZERO_QUANTA = 16'h0000;
	// pause quantum timing
	localparam int QUANTUM_PS = 51200;
	localparam int CLK_PS = 20000;
	localparam int QUANTUM_CYC_RAW = QUANTUM_PS / CLK_PS;
	localparam int QUANTUM_CYC = (QUANTUM_CYC_RAW < 1) ? 1 : QUANTUM_CYC_RAW;
	localparam logic [7:0] QUANTUM_CYC_W = 8'(QUANTUM_CYC);

	// outgoing pause frame fields
	typedef struct packed {
		logic [47:0] da;
		logic [47:0] sa;
		logic [15:0] len_type;
		logic [15:0] opcode;
		logic [15:0] quanta;
	} pause_frame_s;

	// summary of one received frame, from the receive checker
	typedef struct packed {
		logic checks_ok;
		logic [15:0] length;
		logic [47:0] da;
		logic [15:0] len_type;
		logic [15:0] opcode;
		logic [15:0] param;
	} rx_frame_s;
endpackage

/* pause_flow_ctrl.sv */
// What this block does
// R1: trigger builds a pause frame when enabled
// R2: destination is the flow-control multicast address
// R3: source is the configured station address
// R4: duration sampled at trigger assertion into parameter
// R5: idle sends now, busy waits, pause beats clients
// R6: pause frame sent even while held off
// R7: one pending request, latest duration wins
// R8: extended mode only if built-in and standard
// R9: held trigger resends at refresh quanta count
// R10: release with auto xon sends zero quanta
// R11: flow control off, client sends control frames
// R12: control frame good only if 64 bytes
// R13: failing control frames flagged bad
// R14: reception off passes good control frames good
// R15: decode address, type and pause opcode
// R16: failed decode passed up flagged good
// R17: hold transmit acknowledge for received quanta
// R18: acted-on pause flagged bad, statistics good
// R19: client drops control type, stat bit flags
// R20: flow control off, client handles control frames
// R21: client may use full/empty thresholds
// R22: zero-duration pause resumes at once
// R23: one quantum is 512 bit times; the tick here is 2 clocks, 40 ns
// R24: control type recognised and flagged in statistics
// R25: new pause reloads the inhibit counter
// Purpose: pause frame generation and reception for a 10G MAC
// Assumes: tx_busy_i high while the transmitter is sending a frame
// Notes: registers over classic Wishbone, ack one cycle after request
`timescale 1ns/1ps
`default_nettype none
module pause_flow_ctrl
	import pause_fc_pkg::*;
#(
	parameter bit PFC_BUILT = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// client pause request
	input wire logic pause_trigger_i,
	input wire logic [15:0] pause_duration_i,
	// transmitter side
	input wire logic tx_busy_i,
	input wire logic client_tx_req_i,
	output logic client_tx_ack_o,
	output logic pause_send_o,
	output pause_frame_s pause_frame_o,
	// receive side
	input wire logic rx_done_i,
	input wire rx_frame_s rx_frame_i,
	output logic rx_result_o,
	output logic rx_good_o,
	output logic rx_stat_good_o,
	output logic rx_stat_control_o
);
	// configuration registers
	logic [CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
	logic [47:0] sa_reg, sa_next;
	logic [15:0] refresh_reg, refresh_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	// transmit request state
	logic trig_prev_reg, trig_prev_next;
	logic pending_reg, pending_next;
	logic [15:0] dur_reg, dur_next;
	logic held_reg, held_next;
	logic [15:0] held_dur_reg, held_dur_next;
	logic [15:0] since_reg, since_next;
	logic send_reg, send_next;
	pause_frame_s frame_reg, frame_next;
	// quantum timing and inhibit
	logic [7:0] div_reg, div_next;
	logic [15:0] inhibit_reg, inhibit_next;
	// receive results
	logic res_reg, res_next;
	logic good_reg, good_next;
	logic sgood_reg, sgood_next;
	logic sctrl_reg, sctrl_next;
	// decoded controls
	logic tx_en, rx_en, len_dis, ext_mode, auto_xon;
	logic wb_req, tick, launch, trig_rise, trig_held;
	logic is_ctrl, err_free, decode_ok, act;
	logic [31:0] wmask;

	assign tx_en = ctrl_reg[CTRL_TX_EN_BIT];
	assign rx_en = ctrl_reg[CTRL_RX_EN_BIT];
	assign len_dis = ctrl_reg[CTRL_LEN_DIS_BIT];
	assign auto_xon = ctrl_reg[CTRL_AUTO_XON_BIT];
	assign ext_mode = PFC_BUILT && !ctrl_reg[CTRL_PFC_MODE_BIT]; // R8
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
	// byte-lane mask from select lines
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// register file next values
	always_comb begin
		ctrl_next = ctrl_reg;
		sa_next = sa_reg;
		refresh_next = refresh_reg;
		rdata_next = 32'h0000_0000;
		ack_next = wb_req;
		if (wb_req && wb_we_i) begin
			// writes merge under the byte mask
			case (wb_adr_i)
				CTRL_OFS: ctrl_next = CTRL_WIDTH'((32'(ctrl_reg) & ~wmask) | (wb_dat_i & wmask));
				SA_LO_OFS: sa_next[31:0] = (sa_reg[31:0] & ~wmask) | (wb_dat_i & wmask);
				SA_HI_OFS: sa_next[47:32] = (sa_reg[47:32] & ~wmask[15:0])
					| (wb_dat_i[15:0] & wmask[15:0]);
				REFRESH_OFS: refresh_next = (refresh_reg & ~wmask[15:0])
					| (wb_dat_i[15:0] & wmask[15:0]);
				default: ; // unmapped writes ignored
			endcase
		end else if (wb_req) begin
			// reads, unmapped read as zero
			case (wb_adr_i)
				CTRL_OFS: rdata_next = 32'(ctrl_reg);
				SA_LO_OFS: rdata_next = sa_reg[31:0];
				SA_HI_OFS: rdata_next = {16'h0000, sa_reg[47:32]};
				REFRESH_OFS: rdata_next = {16'h0000, refresh_reg};
				STATUS_OFS: rdata_next = {inhibit_reg, 13'h0000, held_reg,
					(inhibit_reg != 16'h0000), pending_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// register file flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
			sa_reg <= SA_RESET;
			refresh_reg <= REFRESH_RESET;
			rdata_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			sa_reg <= sa_next;
			refresh_reg <= refresh_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end
	assign wb_dat_o = rdata_reg;
	assign wb_ack_o = ack_reg;

	// quantum tick: one pulse per 2 clocks, 512 bit times rounded down to whole clocks
	assign tick = (div_reg == QUANTUM_CYC_W - 8'h01); // R23
	// trigger edges, same-clock input
	assign trig_rise = pause_trigger_i && !trig_prev_reg;
	assign trig_held = pause_trigger_i && trig_prev_reg;
	// launch when transmitter is free, regardless of inhibit
	assign launch = pending_reg && !tx_busy_i && tx_en; // R5 R6

	// transmit request next values
	always_comb begin
		trig_prev_next = pause_trigger_i;
		pending_next = pending_reg;
		dur_next = dur_reg;
		held_next = held_reg;
		held_dur_next = held_dur_reg;
		since_next = since_reg;
		send_next = launch;
		frame_next = frame_reg;
		// quanta since last pause frame
		if (launch) begin
			since_next = 16'h0000; // R9
		end else if (tick && since_reg != 16'hFFFF) begin
			since_next = since_reg + 16'h0001;
		end
		// sent frame clears pending unless a new event lands
		if (launch) begin
			pending_next = 1'b0;
			frame_next.da = PAUSE_MCAST_DA; // R2
			frame_next.sa = sa_reg; // R3
			frame_next.len_type = CTRL_TYPE;
			frame_next.opcode = PAUSE_OPCODE;
			frame_next.quanta = dur_reg; // R4
		end
		if (!tx_en) begin
			pending_next = 1'b0;
			held_next = 1'b0;
		end else if (trig_rise) begin
			// latest sample replaces any waiting one
			pending_next = 1'b1; // R1 R7
			dur_next = pause_duration_i; // R4 R7
			held_dur_next = pause_duration_i;
		end else if (ext_mode && trig_held) begin
			held_next = 1'b1;
			if (since_reg >= refresh_reg && !pending_reg && !launch) begin
				pending_next = 1'b1; // R9
				dur_next = held_dur_reg;
			end
		end else if (!pause_trigger_i && held_reg) begin
			held_next = 1'b0;
			if (auto_xon && ext_mode) begin
				pending_next = 1'b1; // R10
				dur_next = ZERO_QUANTA;
			end
		end
	end

	// transmit request flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_prev_reg <= 1'b0;
			pending_reg <= 1'b0;
			dur_reg <= 16'h0000;
			held_reg <= 1'b0;
			held_dur_reg <= 16'h0000;
			since_reg <= 16'h0000;
			send_reg <= 1'b0;
			frame_reg <= '0;
		end else begin
			trig_prev_reg <= trig_prev_next;
			pending_reg <= pending_next;
			dur_reg <= dur_next;
			held_reg <= held_next;
			held_dur_reg <= held_dur_next;
			since_reg <= since_next;
			send_reg <= send_next;
			frame_reg <= frame_next;
		end
	end
	assign pause_send_o = send_reg;
	assign pause_frame_o = frame_reg;
	// client waits for pending pause and for the inhibit to run out
	assign client_tx_ack_o = client_tx_req_i && !tx_busy_i && !pending_reg
		&& !launch && (inhibit_reg == 16'h0000); // R5 R17

	// receive frame classification
	assign is_ctrl = (rx_frame_i.len_type == CTRL_TYPE); // R24
	assign err_free = rx_frame_i.checks_ok
		&& (len_dis || rx_frame_i.length == CTRL_FRAME_BYTES); // R12
	assign decode_ok = (rx_frame_i.da == PAUSE_MCAST_DA || rx_frame_i.da == sa_reg)
		&& is_ctrl && rx_frame_i.opcode == PAUSE_OPCODE; // R15
	assign act = rx_done_i && is_ctrl && err_free && rx_en && decode_ok;

	// receive results and inhibit counter next values
	always_comb begin
		div_next = tick ? 8'h00 : div_reg + 8'h01;
		inhibit_next = inhibit_reg;
		res_next = rx_done_i;
		good_next = good_reg;
		sgood_next = sgood_reg;
		sctrl_next = sctrl_reg;
		if (tick && inhibit_reg != 16'h0000) begin
			inhibit_next = inhibit_reg - 16'h0001; // R17
		end
		if (act) begin
			// a fresh pause replaces what remains, zero resumes
			inhibit_next = rx_frame_i.param; // R22 R25
			div_next = 8'h00;
		end
		if (rx_done_i) begin
			sctrl_next = is_ctrl; // R24
			if (!is_ctrl) begin
				good_next = rx_frame_i.checks_ok;
				sgood_next = rx_frame_i.checks_ok;
			end else if (!err_free) begin
				good_next = 1'b0; // R13
				sgood_next = 1'b0;
			end else if (!rx_en || !decode_ok) begin
				good_next = 1'b1; // R14 R16
				sgood_next = 1'b1;
			end else begin
				good_next = 1'b0; // R18
				sgood_next = 1'b1;
			end
		end
	end

	// receive and inhibit flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= 8'h00;
			inhibit_reg <= 16'h0000;
			res_reg <= 1'b0;
			good_reg <= 1'b0;
			sgood_reg <= 1'b0;
			sctrl_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			inhibit_reg <= inhibit_next;
			res_reg <= res_next;
			good_reg <= good_next;
			sgood_reg <= sgood_next;
			sctrl_reg <= sctrl_next;
		end
	end
	assign rx_result_o = res_reg;
	assign rx_good_o = good_reg;
	assign rx_stat_good_o = sgood_reg;
	assign rx_stat_control_o = sctrl_reg;

	// checks
	property p_trig_pends;
		@(posedge clk_i) disable iff (rst_i)
		(tx_en && trig_rise) |=> pending_reg && dur_reg == $past(pause_duration_i);
	endproperty
	a_trig_pends: assert property (p_trig_pends) else $error("trigger not pended"); // R1
	property p_frame_fields;
		@(posedge clk_i) disable iff (rst_i)
		pause_send_o |-> pause_frame_o.da == PAUSE_MCAST_DA
			&& pause_frame_o.sa == sa_reg && pause_frame_o.opcode == PAUSE_OPCODE;
	endproperty
	a_frame_fields: assert property (p_frame_fields) else $error("bad frame fields"); // R2
	property p_busy_waits;
		@(posedge clk_i) disable iff (rst_i)
		tx_busy_i |=> !pause_send_o;
	endproperty
	a_busy_waits: assert property (p_busy_waits) else $error("sent while busy"); // R5
	property p_send_when_free;
		@(posedge clk_i) disable iff (rst_i)
		// a fresh trigger or an xon release in the launch cycle re-pends on purpose
		(pending_reg && tx_en && !tx_busy_i && !trig_rise && !(held_reg && !pause_trigger_i))
			|=> pause_send_o && !pending_reg;
	endproperty
	a_send_when_free: assert property (p_send_when_free) else $error("free not sent"); // R6
	property p_no_ack_inhibit;
		@(posedge clk_i) disable iff (rst_i)
		(inhibit_reg != 16'h0000) |-> !client_tx_ack_o;
	endproperty
	a_no_ack_inhibit: assert property (p_no_ack_inhibit) else $error("ack while paused"); // R17
	property p_act_reload;
		@(posedge clk_i) disable iff (rst_i)
		act |=> inhibit_reg == $past(rx_frame_i.param);
	endproperty
	a_act_reload: assert property (p_act_reload) else $error("inhibit not loaded"); // R25
	property p_acted_bad;
		@(posedge clk_i) disable iff (rst_i)
		act |=> rx_result_o && !rx_good_o && rx_stat_good_o;
	endproperty
	a_acted_bad: assert property (p_acted_bad) else $error("acted frame flagged"); // R18
	property p_short_bad;
		@(posedge clk_i) disable iff (rst_i)
		(rx_done_i && is_ctrl && !len_dis && rx_frame_i.length != CTRL_FRAME_BYTES)
			|=> !rx_good_o;
	endproperty
	a_short_bad: assert property (p_short_bad) else $error("short control good"); // R13
	property p_xon_zero;
		@(posedge clk_i) disable iff (rst_i)
		(held_reg && !pause_trigger_i && auto_xon && ext_mode && tx_en)
			|=> pending_reg && dur_reg == ZERO_QUANTA;
	endproperty
	a_xon_zero: assert property (p_xon_zero) else $error("no xon queued"); // R10
	// zero-quanta pause drops the inhibit at once
	property p_zero_resume;
		@(posedge clk_i) disable iff (rst_i)
		(act && rx_frame_i.param == ZERO_QUANTA) |=> inhibit_reg == 16'h0000;
	endproperty
	a_zero_resume: assert property (p_zero_resume) else $error("zero pause not resumed"); // R22
	// reception off: clean control frames go up flagged good
	property p_rx_off_good;
		@(posedge clk_i) disable iff (rst_i)
		(rx_done_i && is_ctrl && err_free && !rx_en)
			|=> rx_good_o && rx_stat_good_o && rx_stat_control_o;
	endproperty
	a_rx_off_good: assert property (p_rx_off_good) else $error("control frame not passed"); // R14
	property p_ack_cycle;
		@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_cycle: assert property (p_ack_cycle) else $error("bad wishbone ack");
	c_send: cover property (@(posedge clk_i) disable iff (rst_i) pause_send_o);
	c_act: cover property (@(posedge clk_i) disable iff (rst_i) act);
	c_refresh: cover property (@(posedge clk_i) disable iff (rst_i)
		held_reg && pause_send_o);
	c_resume: cover property (@(posedge clk_i) disable iff (rst_i)
		act && rx_frame_i.param == ZERO_QUANTA && inhibit_reg != 16'h0000);
endmodule
`default_nettype wire

/* pause_link_model.sv */
// Purpose: far side model, remote mac frames in and transmitter busy out
// Assumes: one clock, frames announced by the bench
// Notes: frame lines flip while no frame is announced
`timescale 1ns/1ps
`default_nettype none
module pause_link_model
	import pause_fc_pkg::*;
#(
	parameter int FRAME_CYC = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic send_i,
	input wire rx_frame_s frame_i,
	input wire logic hold_i,
	input wire logic launch_i,
	output logic rx_done_o,
	output rx_frame_s rx_frame_o,
	output logic tx_busy_o
);
	// cycles left of the frame on the wire
	logic [7:0] busy_reg;
	logic [7:0] busy_next;
	// each launch occupies the wire for one frame time
	always_comb begin
		busy_next = busy_reg - 8'(busy_reg != 8'h00);
		if (launch_i) begin
			busy_next = 8'(FRAME_CYC);
		end
	end
	// stale summary is inverted every cycle between frames, so it never holds steady
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_reg <= 8'h00;
			rx_done_o <= 1'b0;
			rx_frame_o <= '0;
		end else begin
			busy_reg <= busy_next;
			rx_done_o <= send_i;
			rx_frame_o <= send_i ? frame_i : ~rx_frame_o;
		end
	end
	// hold lets the bench keep the wire busy
	assign tx_busy_o = hold_i | (busy_reg != 8'h00);
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench for the pause flow control block
// Assumes: ack one cycle after request, quantum of two cycles
// Notes: expected frames and flags are queued, a monitor compares
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb
	import pause_fc_pkg::*;
;
	logic clk_i, rst_i, cyc, stb, we, trig, req, send, hold, busy, done;
	logic ack, ack_tx, psend, res, good, sgood, sctrl;
	logic [7:0] adr;
	logic [31:0] dat, rdat, rd_o;
	logic [15:0] dur, d, p;
	rx_frame_s fr, frw;
	pause_frame_s pfr;
	pause_frame_s exp_tx[$];
	logic [2:0] exp_rx[$];
	// oldest notes, popped once before comparing
	pause_frame_s pexp;
	logic [2:0] rexp;
	int n_fail, checks_done, n_frames, cyc_cnt, n;
	int seed = 32'h66e1;
	logic [47:0] sa = 48'h0a11_2233_4455;
	pause_flow_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd_o),
		.wb_ack_o(ack), .pause_trigger_i(trig), .pause_duration_i(dur), .tx_busy_i(busy),
		.client_tx_req_i(req), .client_tx_ack_o(ack_tx), .pause_send_o(psend),
		.pause_frame_o(pfr), .rx_done_i(done), .rx_frame_i(frw), .rx_result_o(res),
		.rx_good_o(good), .rx_stat_good_o(sgood), .rx_stat_control_o(sctrl));
	pause_link_model peer (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .frame_i(fr),
		.hold_i(hold), .launch_i(psend | ack_tx), .rx_done_o(done), .rx_frame_o(frw),
		.tx_busy_o(busy));
	// verdict and end of run
	task automatic end_sim();
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one classic wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = rd_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// one-cycle trigger pulse with a duration
	task automatic trg(input logic [15:0] v);
		@(posedge clk_i);
		trig <= 1'b1;
		dur <= v;
		@(posedge clk_i);
		trig <= 1'b0;
	endtask
	// expected pause frame with given quanta
	task automatic want(input logic [15:0] q);
		exp_tx.push_back('{PAUSE_MCAST_DA, sa, CTRL_TYPE, PAUSE_OPCODE, q});
	endtask
	// announce one received frame and wait for its result
	task automatic rxf(input logic ok, input logic [15:0] ln, input logic [47:0] da,
		input logic [15:0] ty, input logic [15:0] op, input logic [15:0] pq,
		input logic [2:0] e);
		exp_rx.push_back(e);
		@(posedge clk_i);
		send <= 1'b1;
		fr <= '{ok, ln, da, ty, op, pq};
		@(posedge clk_i);
		send <= 1'b0;
		do @(posedge clk_i); while (res !== 1'b1);
	endtask
	// wait for a count of launched pause frames
	task automatic wf(input int k);
		while (n_frames < k) @(posedge clk_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// timeout: a hang counts as a mismatch
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt > 4000) begin
			n_fail++;
			end_sim();
		end
	end
	// monitor: compares launches and receive results with the notes
	always @(posedge clk_i) begin
		if (!rst_i && psend === 1'b1) begin
			n_frames++;
			if (exp_tx.size() == 0) begin
				`CHK(psend, 1'b0)
			end else begin
				pexp = exp_tx.pop_front();
				`CHK(pfr, pexp)
			end
		end
		// compare the good, statistics good and control flags of each result with the oldest note
		if (!rst_i && res === 1'b1 && exp_rx.size() != 0) begin
			rexp = exp_rx.pop_front();
			`CHK({good, sgood, sctrl}, rexp)
		end
	end
	// main sequence
	initial begin
		{rst_i, cyc, stb, we, trig, req, send, hold} = 8'h80;
		adr = 8'h00;
		dat = 32'h0000_0000;
		dur = 16'h0000;
		fr = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REFRESH_OFS, 32'h0000_0000);
		`CHK(rdat, 32'h0000_ff00)
		wb(1'b0, 8'h20, 32'h0000_0000);
		`CHK(rdat, 32'h0000_0000)
		wb(1'b1, SA_LO_OFS, sa[31:0]);
		wb(1'b1, SA_HI_OFS, {16'h0000, sa[47:32]});
		wb(1'b1, CTRL_OFS, 32'h0000_0003);
		wb(1'b0, SA_HI_OFS, 32'h0000_0000);
		`CHK(rdat[15:0], sa[47:32])
		// idle transmitter sends at once
		d = 16'($random(seed));
		want(d);
		trg(d);
		wf(1);
		// retriggers while busy merge into one frame
		hold <= 1'b1;
		trg(16'($random(seed)));
		d = 16'($random(seed));
		want(d);
		trg(d);
		repeat (4) @(posedge clk_i);
		hold <= 1'b0;
		wf(2);
		repeat (10) @(posedge clk_i);
		// receive checks and decode
		rxf(1'b0, 16'h0040, PAUSE_MCAST_DA, CTRL_TYPE, PAUSE_OPCODE, 16'h0000, 3'b001);
		rxf(1'b1, 16'h0041, PAUSE_MCAST_DA, CTRL_TYPE, PAUSE_OPCODE, 16'h0000, 3'b001);
		rxf(1'b1, 16'h0040, PAUSE_MCAST_DA, CTRL_TYPE, 16'h0002, 16'h0000, 3'b111);
		rxf(1'b1, 16'h0040, sa, CTRL_TYPE, PAUSE_OPCODE, 16'h0000, 3'b011);
		rxf(1'b1, 16'h0040, PAUSE_MCAST_DA, 16'h0800, PAUSE_OPCODE, 16'h0000, 3'b110);
		wb(1'b1, CTRL_OFS, 32'h0000_0007);
		rxf(1'b1, 16'h0041, PAUSE_MCAST_DA, CTRL_TYPE, PAUSE_OPCODE, 16'h0000, 3'b011);
		wb(1'b1, CTRL_OFS, 32'h0000_0001);
		rxf(1'b1, 16'h0040, PAUSE_MCAST_DA, CTRL_TYPE, PAUSE_OPCODE, 16'h0000, 3'b111);
		// received pause holds client ack for its quanta
		wb(1'b1, CTRL_OFS, 32'h0000_0003);
		p = 16'h0005 + 16'($random(seed) & 15);
		rxf(1'b1, 16'h0040, PAUSE_MCAST_DA, CTRL_TYPE, PAUSE_OPCODE, p, 3'b011);
		n = 0;
		req <= 1'b1;
		while (ack_tx !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		`CHK(n >= 2 * p - 4 && n <= 2 * p + 2, 1'b1)
		req <= 1'b0;
		repeat (8) @(posedge clk_i);
		// long pause, local request still sent, then zero pause resumes
		rxf(1'b1, 16'h0040, PAUSE_MCAST_DA, CTRL_TYPE, PAUSE_OPCODE, 16'hffff, 3'b011);
		d = 16'($random(seed));
		want(d);
		trg(d);
		wf(3);
		rxf(1'b1, 16'h0040, PAUSE_MCAST_DA, CTRL_TYPE, PAUSE_OPCODE, 16'h0000, 3'b011);
		n = 0;
		req <= 1'b1;
		while (ack_tx !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		`CHK(n <= 3, 1'b1)
		req <= 1'b0;
		// held trigger refreshes, release sends zero quanta
		wb(1'b1, REFRESH_OFS, 32'h0000_0003);
		wb(1'b1, CTRL_OFS, 32'h0000_0011);
		d = 16'($random(seed));
		want(d);
		want(d);
		want(ZERO_QUANTA);
		@(posedge clk_i);
		trig <= 1'b1;
		dur <= d;
		wf(5);
		trig <= 1'b0;
		wf(6);
		// priority mode set: no refresh and no zero frame
		wb(1'b1, CTRL_OFS, 32'h0000_0019);
		d = 16'($random(seed));
		want(d);
		@(posedge clk_i);
		trig <= 1'b1;
		dur <= d;
		repeat (20) @(posedge clk_i);
		trig <= 1'b0;
		repeat (20) @(posedge clk_i);
		// flow control off: trigger ignored, client frame goes straight out
		wb(1'b1, CTRL_OFS, 32'h0000_0000);
		trg(16'($random(seed)));
		req <= 1'b1;
		@(posedge clk_i);
		`CHK(ack_tx, 1'b1)
		req <= 1'b0;
		repeat (10) @(posedge clk_i);
		`CHK(exp_tx.size(), 0)
		`CHK(exp_rx.size(), 0)
		end_sim();
	end
endmodule
`default_nettype wire
